// ==== logic/wave_ctrl_regs.vh ====
`ifndef WAVE_CTRL_REGS_VH
`define WAVE_CTRL_REGS_VH
// ----------------------------------------
// Geometry and limits
// ----------------------------------------
`define PTS       10'h200
`define LIM_HI    17'h00800
`define LIM_LO    17'h1f800
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CMD   8'h00
`define OFS_CFG   8'h04
`define OFS_STAT  8'h08
`define OFS_ZREF  8'h0c
`define OFS_STACK 8'h10
`define OFS_MADDR 8'h14
`define OFS_MDATA 8'h18
`define OFS_SCALE 8'h1c
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CMD_UP    0
`define CMD_DN    1
`define CMD_REP   2
`define CMD_SGL   3
`define CFG_RST   8'h14
`define SCALE_DEF 8'h01
// ----------------------------------------
// Thresholds and timing
// ----------------------------------------
`define FILL_PCT  99
`define GAP_PCT   5
`define CLK_MHZ   50
`define HOLD_MS   300
`define REPEAT_MS 20
`endif

// ==== logic/waveform_acquire_and_vposition.v ====
`timescale 1ns/1ps
`include "wave_ctrl_regs.vh"
module waveform_acquire_and_vposition #(
  parameter [23:0] HOLD_CYCLES   = `HOLD_MS * `CLK_MHZ * 1000,
  parameter [23:0] REPEAT_CYCLES = `REPEAT_MS * `CLK_MHZ * 1000
) (
  input  wire        i_core_clk,
  input  wire        i_resetn,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  input  wire        i_key_up,
  input  wire        i_key_down,
  input  wire        i_key_halt,
  input  wire        i_abort,
  input  wire        i_acq_valid,
  input  wire        i_sweep_end,
  input  wire [8:0]  i_acq_index,
  input  wire [15:0] i_acq_data0,
  input  wire [15:0] i_acq_data1,
  input  wire [7:0]  i_scale0,
  input  wire [7:0]  i_scale1,
  output reg         o_busy,
  output reg         o_done,
  output reg         o_warn,
  output reg         o_show_live,
  output reg         o_show_stored,
  output reg         o_input_blocked
);
  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_NCHK  = 4'h1;
  localparam [3:0] S_NAPP  = 4'h2;
  localparam [3:0] S_RRUN  = 4'h3;
  localparam [3:0] S_RPOST = 4'h4;
  localparam [3:0] S_FILL  = 4'h5;
  localparam [3:0] S_ZERO  = 4'h6;
  localparam [3:0] S_SRUN  = 4'h7;
  localparam [3:0] S_SCOPY = 4'h8;
  localparam [3:0] S_FIN   = 4'h9;
  localparam [9:0] NPTS    = `PTS;
  localparam [9:0] NLAST   = `PTS - 10'h001;

  reg [63:0] wave  [0:`PTS-1];
  reg [31:0] stage [0:`PTS-1];

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [62:0] sync1_q;
  reg [62:0] sync2_q;
  reg [4:0]  prev_q;
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_q <= 63'h0;
      sync2_q <= 63'h0;
      prev_q  <= 5'h00;
    end else begin
      sync1_q <= {i_key_up, i_key_down, i_key_halt, i_abort, i_acq_valid, i_sweep_end,
                  i_acq_index, i_acq_data0, i_acq_data1, i_scale0, i_scale1};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q[62:58];
    end
  end
  wire        key_up   = sync2_q[62];
  wire        key_dn   = sync2_q[61];
  wire        halt_ev  = sync2_q[60] & ~prev_q[2];
  wire        abort_ev = sync2_q[59] & ~prev_q[1];
  wire        acq_ev   = sync2_q[58] & ~prev_q[0];
  wire        swp_ev   = sync2_q[57];
  wire [8:0]  acq_idx  = sync2_q[56:48];
  wire [15:0] d0       = sync2_q[47:32];
  wire [15:0] d1       = sync2_q[31:16];
  wire        up_ev    = key_up & ~prev_q[4];
  wire        dn_ev    = key_dn & ~prev_q[3];

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [3:0]       state_q;
  reg [7:0]       cfg_q;
  reg [15:0]      zref_q;
  reg [10:0]      maddr_q;
  reg [1:0]       x_q;
  reg [1:0]       y_q;
  reg [7:0]       sc0_q;
  reg [7:0]       sc1_q;
  reg [9:0]       idx_q;
  reg [9:0]       j_q;
  reg [9:0]       fend_q;
  reg [9:0]       last_q;
  reg [9:0]       il_q;
  reg [9:0]       ir_q;
  reg [9:0]       run_q;
  reg [9:0]       maxrun_q;
  reg [9:0]       fcnt_q;
  reg [9:0]       scnt_q;
  reg [8:0]       wptr_q;
  reg [`PTS-1:0]  filled_q;
  reg [15:0]      lv0_q;
  reg [15:0]      lv1_q;
  reg [15:0]      rv0_q;
  reg [15:0]      rv1_q;
  reg [23:0]      hold_q;
  reg             have_last_q;
  reg             sweep_seen_q;
  reg             two_q;
  reg             dir_q;
  reg             refused_q;
  reg             clip_q;
  reg             acq_warn_q;
  reg             blocked_q;
  reg             halted_q;

  wire [1:0] op_slot = cfg_q[1:0];
  wire       live    = cfg_q[2];
  wire       chop    = cfg_q[3];
  wire [2:0] rtcnt   = cfg_q[6:4];
  wire       nonuniq = cfg_q[7];

  // ----------------------------------------
  // APB decode and command requests
  // ----------------------------------------
  wire apb_wr  = i_psel & i_penable & i_pwrite;
  wire cmd_wr  = apb_wr & (i_paddr == `OFS_CMD);
  wire held    = key_up | key_dn;
  wire rpt     = held & (hold_q == HOLD_CYCLES);
  wire req_up  = (cmd_wr & i_pwdata[`CMD_UP]) | (key_up & (up_ev | rpt));
  wire req_dn  = (cmd_wr & i_pwdata[`CMD_DN]) | (key_dn & (dn_ev | rpt));
  wire req_rep = cmd_wr & i_pwdata[`CMD_REP];
  wire req_sgl = cmd_wr & i_pwdata[`CMD_SGL];

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  reg  [9:0]  rd_idx;
  reg         we;
  reg  [3:0]  wm;
  reg  [15:0] wv0;
  reg  [15:0] wv1;
  reg  [15:0] wvx;
  reg  [63:0] wrow;
  integer     k;
  wire [63:0] row   = wave[rd_idx[8:0]];
  wire [63:0] mrow  = wave[maddr_q[8:0]];
  wire [15:0] op_pt = row[op_slot*16 +: 16];
  wire [16:0] stp   = {op_pt[15], op_pt} + (dir_q ? 17'h00001 : 17'h1ffff);
  wire        st_hi = $signed(stp) > $signed(`LIM_HI);
  wire        st_lo = $signed(stp) < $signed(`LIM_LO);
  wire [16:0] clipw = st_hi ? `LIM_HI : (st_lo ? `LIM_LO : stp);
  wire [15:0] clipv = clipw[15:0];
  wire        z_hi  = $signed({zref_q[15], zref_q}) >= $signed(`LIM_HI);
  wire        z_lo  = $signed({zref_q[15], zref_q}) <= $signed(`LIM_LO);
  wire [9:0]  jo    = j_q - il_q;
  wire [9:0]  den   = ir_q - il_q;
  wire signed [16:0] df0 = $signed({rv0_q[15], rv0_q}) - $signed({lv0_q[15], lv0_q});
  wire signed [16:0] df1 = $signed({rv1_q[15], rv1_q}) - $signed({lv1_q[15], lv1_q});
  wire signed [27:0] n0  = df0 * $signed({1'b0, jo});
  wire signed [27:0] n1  = df1 * $signed({1'b0, jo});
  wire signed [27:0] q0  = n0 / $signed({18'h00000, den});
  wire signed [27:0] q1  = n1 / $signed({18'h00000, den});
  wire [15:0] iv0   = lv0_q + q0[15:0];
  wire [15:0] iv1   = lv1_q + q1[15:0];
  wire [9:0]  lead  = NPTS - scnt_q;
  wire [9:0]  jl    = j_q - lead;
  wire [8:0]  wsum  = wptr_q + j_q[8:0];
  wire [8:0]  src   = (scnt_q == NPTS) ? wsum : ((j_q < lead) ? 9'h000 : jl[8:0]);
  wire [31:0] srow  = stage[src];
  wire [3:0]  pair  = {2'b00, two_q, 1'b1};

  always @* begin
    rd_idx = idx_q;
    we     = 1'b0;
    wm     = 4'h0;
    wv0    = 16'h0000;
    wv1    = 16'h0000;
    wvx    = 16'h0000;
    case (state_q)
      S_IDLE: begin
        rd_idx = {1'b0, maddr_q[8:0]};
        we     = apb_wr & (i_paddr == `OFS_MDATA);
        wm     = 4'h1 << maddr_q[10:9];
        wv0    = i_pwdata[15:0];
        wv1    = i_pwdata[15:0];
        wvx    = i_pwdata[15:0];
      end
      S_NAPP: begin
        we  = 1'b1;
        wm  = 4'h1 << op_slot;
        wv0 = clipv;
        wv1 = clipv;
        wvx = clipv;
      end
      S_RRUN: begin
        rd_idx = {1'b0, acq_idx};
        we     = acq_ev;
        wm     = pair;
        wv0    = d0;
        wv1    = d1;
      end
      S_FILL: begin
        rd_idx = j_q;
        we     = 1'b1;
        wm     = pair;
        wv0    = iv0;
        wv1    = iv1;
      end
      S_ZERO: begin
        rd_idx = j_q;
        we     = 1'b1;
        wm     = pair;
      end
      S_SCOPY: begin
        rd_idx = j_q;
        we     = 1'b1;
        wm     = pair;
        wv0    = srow[15:0];
        wv1    = srow[31:16];
      end
      default: begin
        we = 1'b0;
      end
    endcase
    wrow = row;
    for (k = 0; k < 4; k = k + 1) begin
      if (wm[k]) begin
        wrow[k*16 +: 16] = (k == 0) ? wv0 : ((k == 1) ? wv1 : wvx);
      end
    end
  end

  always @(posedge i_core_clk) begin
    if (we) begin
      wave[rd_idx[8:0]] <= wrow;
    end
    if ((state_q == S_SRUN) && acq_ev) begin
      stage[wptr_q] <= {d1, d0};
    end
  end

  // ----------------------------------------
  // Control
  // ----------------------------------------
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= S_IDLE;   cfg_q <= `CFG_RST;    zref_q <= 16'h0000;  maddr_q <= 11'h000;
      x_q <= 2'h0;         y_q <= 2'h0;          sc0_q <= `SCALE_DEF; sc1_q <= `SCALE_DEF;
      idx_q <= 10'h000;    j_q <= 10'h000;       fend_q <= 10'h000;   last_q <= 10'h000;
      il_q <= 10'h000;     ir_q <= 10'h000;      run_q <= 10'h000;    maxrun_q <= 10'h000;
      fcnt_q <= 10'h000;   scnt_q <= 10'h000;    wptr_q <= 9'h000;    filled_q <= {`PTS{1'b0}};
      lv0_q <= 16'h0000;   lv1_q <= 16'h0000;    rv0_q <= 16'h0000;   rv1_q <= 16'h0000;
      hold_q <= 24'h000000; have_last_q <= 1'b0; sweep_seen_q <= 1'b0; two_q <= 1'b0;
      dir_q <= 1'b0;       refused_q <= 1'b0;    clip_q <= 1'b0;      acq_warn_q <= 1'b0;
      blocked_q <= 1'b0;   halted_q <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (!held) begin
        hold_q <= 24'h000000;
      end else if (hold_q == HOLD_CYCLES) begin
        hold_q <= HOLD_CYCLES - REPEAT_CYCLES;
      end else begin
        hold_q <= hold_q + 24'h000001;
      end
      if (apb_wr && (state_q == S_IDLE)) begin
        case (i_paddr)
          `OFS_CFG:   cfg_q   <= i_pwdata[7:0];
          `OFS_ZREF:  zref_q  <= i_pwdata[15:0];
          `OFS_MADDR: maddr_q <= i_pwdata[10:0];
          default:    cfg_q   <= cfg_q;
        endcase
      end
      case (state_q)
        S_IDLE: begin
          if (req_up | req_dn) begin
            dir_q     <= req_up;
            clip_q    <= 1'b0;
            blocked_q <= 1'b0;
            idx_q     <= 10'h000;
            if (req_up ? z_hi : z_lo) begin
              blocked_q <= 1'b1;
            end else begin
              state_q <= (op_slot == 2'h0) ? S_NAPP : S_NCHK;
            end
          end else if (req_rep) begin
            refused_q <= 1'b0;
            if ((rtcnt > 3'h2) || chop) begin
              refused_q <= 1'b1;
            end else begin
              filled_q     <= {`PTS{1'b0}};
              fcnt_q       <= 10'h000;
              sweep_seen_q <= 1'b0;
              halted_q     <= 1'b0;
              acq_warn_q   <= nonuniq;
              two_q        <= (rtcnt == 3'h2);
              sc0_q        <= sync2_q[15:8];
              sc1_q        <= sync2_q[7:0];
              state_q      <= S_RRUN;
            end
          end else if (req_sgl) begin
            wptr_q     <= 9'h000;
            scnt_q     <= 10'h000;
            acq_warn_q <= 1'b0;
            two_q      <= (rtcnt == 3'h2);
            sc0_q      <= sync2_q[15:8];
            sc1_q      <= sync2_q[7:0];
            state_q    <= S_SRUN;
          end
        end
        S_NCHK: begin
          if (st_hi | st_lo) begin
            blocked_q <= 1'b1;
            state_q   <= S_IDLE;
          end else if (idx_q == NLAST) begin
            idx_q   <= 10'h000;
            state_q <= S_NAPP;
          end else begin
            idx_q <= idx_q + 10'h001;
          end
        end
        S_NAPP: begin
          if (st_hi | st_lo) begin
            clip_q <= 1'b1;
          end
          if (idx_q == NLAST) begin
            zref_q  <= zref_q + (dir_q ? 16'h0001 : 16'hffff);
            o_done  <= 1'b1;
            state_q <= S_IDLE;
          end else begin
            idx_q <= idx_q + 10'h001;
          end
        end
        S_RRUN: begin
          if (acq_ev && !filled_q[acq_idx]) begin
            filled_q[acq_idx] <= 1'b1;
            fcnt_q            <= fcnt_q + 10'h001;
          end
          if (swp_ev) begin
            sweep_seen_q <= 1'b1;
          end
          if (halt_ev || (sweep_seen_q && (fcnt_q * 100 >= `FILL_PCT * `PTS))) begin
            if (halt_ev) begin
              halted_q   <= 1'b1;
              acq_warn_q <= 1'b1;
            end
            idx_q       <= 10'h000;
            have_last_q <= 1'b0;
            run_q       <= 10'h000;
            maxrun_q    <= 10'h000;
            state_q     <= S_RPOST;
          end
        end
        S_RPOST: begin
          if (idx_q == NPTS) begin
            if (!have_last_q) begin
              j_q        <= 10'h000;
              acq_warn_q <= 1'b1;
              state_q    <= S_ZERO;
            end else if (last_q != NLAST) begin
              j_q     <= last_q + 10'h001;
              fend_q  <= NLAST;
              il_q    <= last_q;
              ir_q    <= NPTS;
              rv0_q   <= lv0_q;
              rv1_q   <= lv1_q;
              last_q  <= NLAST;
              state_q <= S_FILL;
            end else begin
              if (maxrun_q * 100 > `GAP_PCT * `PTS) begin
                acq_warn_q <= 1'b1;
              end
              state_q <= S_FIN;
            end
          end else if (filled_q[idx_q[8:0]]) begin
            run_q       <= 10'h000;
            last_q      <= idx_q;
            have_last_q <= 1'b1;
            rv0_q       <= row[15:0];
            rv1_q       <= row[31:16];
            if (!have_last_q && (idx_q != 10'h000)) begin
              lv0_q   <= row[15:0];
              lv1_q   <= row[31:16];
              j_q     <= 10'h000;
              fend_q  <= idx_q - 10'h001;
              il_q    <= 10'h000;
              ir_q    <= idx_q;
              state_q <= S_FILL;
            end else if (have_last_q && (idx_q != last_q + 10'h001)) begin
              j_q     <= last_q + 10'h001;
              fend_q  <= idx_q - 10'h001;
              il_q    <= last_q;
              ir_q    <= idx_q;
              state_q <= S_FILL;
            end else begin
              lv0_q <= row[15:0];
              lv1_q <= row[31:16];
              idx_q <= idx_q + 10'h001;
            end
          end else begin
            run_q <= run_q + 10'h001;
            if (run_q + 10'h001 > maxrun_q) begin
              maxrun_q <= run_q + 10'h001;
            end
            idx_q <= idx_q + 10'h001;
          end
        end
        S_FILL: begin
          if (j_q == fend_q) begin
            lv0_q   <= rv0_q;
            lv1_q   <= rv1_q;
            state_q <= S_RPOST;
            if (idx_q != NPTS) begin
              idx_q <= idx_q + 10'h001;
            end
          end else begin
            j_q <= j_q + 10'h001;
          end
        end
        S_ZERO: begin
          if (j_q == NLAST) begin
            sc0_q   <= `SCALE_DEF;
            sc1_q   <= `SCALE_DEF;
            zref_q  <= 16'h0000;
            state_q <= S_FIN;
          end else begin
            j_q <= j_q + 10'h001;
          end
        end
        S_SRUN: begin
          if (acq_ev) begin
            wptr_q <= wptr_q + 9'h001;
            if (scnt_q != NPTS) begin
              scnt_q <= scnt_q + 10'h001;
            end
          end
          if (swp_ev | abort_ev) begin
            j_q     <= 10'h000;
            state_q <= (scnt_q == 10'h000) ? S_ZERO : S_SCOPY;
          end
        end
        S_SCOPY: begin
          if (j_q == NLAST) begin
            state_q <= S_FIN;
          end else begin
            j_q <= j_q + 10'h001;
          end
        end
        S_FIN: begin
          x_q     <= 2'h0;
          y_q     <= two_q ? 2'h1 : x_q;
          o_done  <= 1'b1;
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Outputs and APB read
  // ----------------------------------------
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_prdata        <= 32'h00000000;
      o_pready        <= 1'b0;
      o_pslverr       <= 1'b0;
      o_busy          <= 1'b0;
      o_warn          <= 1'b0;
      o_show_live     <= 1'b0;
      o_show_stored   <= 1'b0;
      o_input_blocked <= 1'b0;
    end else begin
      o_pready        <= 1'b1;
      o_busy          <= (state_q != S_IDLE);
      o_warn          <= clip_q | acq_warn_q;
      o_input_blocked <= (state_q == S_SRUN);
      o_show_live     <= (state_q == S_SRUN) | live;
      o_show_stored   <= (state_q != S_SRUN) & ~live;
      if (i_psel && !i_penable) begin
        o_pslverr <= 1'b0;
        case (i_paddr)
          `OFS_CMD:   o_prdata <= 32'h00000000;
          `OFS_CFG:   o_prdata <= {24'h000000, cfg_q};
          `OFS_STAT:  o_prdata <= {25'h0000000, halted_q, blocked_q, acq_warn_q, clip_q,
                                   refused_q, (state_q == S_SRUN), (state_q != S_IDLE)};
          `OFS_ZREF:  o_prdata <= {16'h0000, zref_q};
          `OFS_STACK: o_prdata <= {22'h000000, y_q, 6'h00, x_q};
          `OFS_MADDR: o_prdata <= {21'h000000, maddr_q};
          `OFS_MDATA: o_prdata <= {16'h0000, mrow[maddr_q[10:9]*16 +: 16]};
          `OFS_SCALE: o_prdata <= {16'h0000, sc1_q, sc0_q};
          default: begin
            o_prdata  <= 32'h00000000;
            o_pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule // waveform_acquire_and_vposition

// ==== bench/wave_ctrl_monitor.sv ====
`timescale 1ns/1ps
module wave_ctrl_monitor (
  input wire       i_core_clk,
  input wire       i_resetn,
  input wire       i_psel,
  input wire       i_penable,
  input wire [7:0] i_paddr,
  input wire       i_abort,
  input wire       i_sweep_end,
  input wire       o_pready,
  input wire       o_pslverr,
  input wire       o_busy,
  input wire       o_done,
  input wire       o_warn,
  input wire       o_show_live,
  input wire       o_show_stored,
  input wire       o_input_blocked
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_abort_hit; o_input_blocked ##0 $rose(i_abort); endsequence
  sequence s_end_hit; o_input_blocked ##0 $rose(i_sweep_end); endsequence
  sequence s_held; o_input_blocked ##0 $past(o_input_blocked); endsequence
  a_done_one_cycle: assert property (o_done |=> !o_done)
    else $error("done pulse longer than one cycle");
  a_done_after_busy: assert property ($rose(o_done) |-> $past(o_busy))
    else $error("done without preceding busy");
  a_done_then_idle: assert property (o_done |-> ##[0:2] !o_busy)
    else $error("busy stays after done");
  a_block_sets_busy: assert property ($rose(o_input_blocked) |-> ##[0:1] o_busy)
    else $error("blocked without busy");
  a_block_live_only: assert property (s_held |-> o_show_live && !o_show_stored)
    else $error("stored shown in single sweep");
  a_block_no_warn: assert property (s_held |-> !o_warn)
    else $error("warning during single sweep");
  a_abort_ends_sweep: assert property (s_abort_hit |-> ##[3:600] o_done)
    else $error("abort missed");
  a_end_ends_sweep: assert property (s_end_hit |-> ##[3:600] o_done)
    else $error("completion missed");
  a_apb_zero_wait: assert property (i_psel && !i_penable |=> o_pready)
    else $error("access phase without ready");
  a_unmapped_error: assert property (i_psel && i_penable && i_paddr > 8'h1c |-> o_pslverr)
    else $error("unmapped access without error");
endmodule // wave_ctrl_monitor

bind waveform_acquire_and_vposition wave_ctrl_monitor mon (.i_core_clk, .i_resetn, .i_psel,
  .i_penable, .i_paddr, .i_abort, .i_sweep_end, .o_pready, .o_pslverr, .o_busy, .o_done,
  .o_warn, .o_show_live, .o_show_stored, .o_input_blocked);

// ==== bench/keypad_digitizer_model.sv ====
`timescale 1ns/1ps
module keypad_digitizer_model (
  input  wire         i_core_clk,
  output logic        o_key_up,
  output logic        o_key_down,
  output logic        o_key_halt,
  output logic        o_abort,
  output logic        o_acq_valid,
  output logic        o_sweep_end,
  output logic [8:0]  o_acq_index,
  output logic [15:0] o_acq_data0,
  output logic [15:0] o_acq_data1,
  output logic [7:0]  o_scale0,
  output logic [7:0]  o_scale1
);
  initial begin
    {o_key_up, o_key_down, o_key_halt, o_abort, o_acq_valid, o_sweep_end} = 6'h00;
    {o_acq_index, o_acq_data0, o_acq_data1} = 41'h0;
    o_scale0 = 8'h23;
    o_scale1 = 8'h45;
  end
  // Key k: 0 up, 1 down, other halt, held n cycles
  task press(input int k, input int n);
    @(posedge i_core_clk);
    case (k)
      0: o_key_up <= 1'b1;
      1: o_key_down <= 1'b1;
      default: o_key_halt <= 1'b1;
    endcase
    repeat (n) @(posedge i_core_clk);
    {o_key_up, o_key_down, o_key_halt} <= 3'h0;
    repeat (4) @(posedge i_core_clk);
  endtask
  // One sample strobe, data scrambled after hold
  task sample(input logic [8:0] idx, input logic [15:0] d0, input logic [15:0] d1);
    @(posedge i_core_clk);
    {o_acq_index, o_acq_data0, o_acq_data1} <= {idx, d0, d1};
    @(posedge i_core_clk);
    o_acq_valid <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    o_acq_valid <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    {o_acq_data0, o_acq_data1} <= ~{d0, d1};
  endtask
  // Completion (k 0) or abort (k 1) pulse
  task pulse(input int k);
    @(posedge i_core_clk);
    if (k == 0) o_sweep_end <= 1'b1; else o_abort <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    {o_sweep_end, o_abort} <= 2'h0;
  endtask
endmodule // keypad_digitizer_model

// ==== bench/waveform_acquire_and_vposition_tb.sv ====
`timescale 1ns/1ps
`include "wave_ctrl_regs.vh"
module waveform_acquire_and_vposition_tb;
  logic        i_core_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  wire  [31:0] o_prdata;
  wire         o_pready, o_pslverr, o_busy, o_done, o_warn;
  wire         o_show_live, o_show_stored, o_input_blocked;
  wire         ku, kd, kh, ab, av, se;
  wire  [8:0]  ix;
  wire  [15:0] d0, d1;
  wire  [7:0]  s0, s1;
  logic [31:0] rd;
  logic        er;
  int          error_cnt = 0;
  int          total_checks = 0;
  always #10 i_core_clk = ~i_core_clk;
  waveform_acquire_and_vposition #(.HOLD_CYCLES(24'd40), .REPEAT_CYCLES(24'd10)) uut (
    .i_core_clk, .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_key_up(ku), .i_key_down(kd), .i_key_halt(kh),
    .i_abort(ab), .i_acq_valid(av), .i_sweep_end(se), .i_acq_index(ix), .i_acq_data0(d0),
    .i_acq_data1(d1), .i_scale0(s0), .i_scale1(s1), .o_busy, .o_done, .o_warn,
    .o_show_live, .o_show_stored, .o_input_blocked);
  keypad_digitizer_model pm (.i_core_clk, .o_key_up(ku), .o_key_down(kd), .o_key_halt(kh),
    .o_abort(ab), .o_acq_valid(av), .o_sweep_end(se), .o_acq_index(ix), .o_acq_data0(d0),
    .o_acq_data1(d1), .o_scale0(s0), .o_scale1(s1));
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_core_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    {i_psel, i_penable} <= 2'h0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, rd & m, e);
  endtask
  task wd(input int lim);
    int n;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_done !== 1'b1 && n < lim);
    check("done", {31'h0, o_done}, 32'h1);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge i_core_clk);
    error_cnt++;
    wrap_up;
  end
  initial begin
    repeat (10) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    rc("cfg", `OFS_CFG, 32'hff, 32'h14);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped", {31'h0, er}, 32'h1);
    $display("reset test done");
    wr(`OFS_CMD, 32'h1);
    wd(1200);
    rc("zref up", `OFS_ZREF, 32'hffff, 32'h1);
    wr(`OFS_CMD, 32'h2);
    wd(1200);
    rc("zref down", `OFS_ZREF, 32'hffff, 32'h0);
    pm.press(0, 5);
    wd(1200);
    rc("zref key", `OFS_ZREF, 32'hffff, 32'h1);
    pm.press(0, 1500);
    repeat (1200) @(posedge i_core_clk);
    apb(1'b0, `OFS_ZREF, 32'h0);
    check("zref repeat", {31'h0, rd[15:0] > 16'h2}, 32'h1);
    $display("nudge test done");
    wr(`OFS_ZREF, 32'h800);
    wr(`OFS_CMD, 32'h1);
    rc("up blocked", `OFS_STAT, 32'h20, 32'h20);
    rc("zref top", `OFS_ZREF, 32'hffff, 32'h800);
    wr(`OFS_ZREF, 32'hf800);
    wr(`OFS_CMD, 32'h2);
    rc("dn blocked", `OFS_STAT, 32'h20, 32'h20);
    rc("zref bottom", `OFS_ZREF, 32'hffff, 32'hf800);
    wr(`OFS_ZREF, 32'h0);
    wr(`OFS_MADDR, 32'h5);
    wr(`OFS_MDATA, 32'h800);
    wr(`OFS_CMD, 32'h1);
    wd(1200);
    rc("clip hi", `OFS_MDATA, 32'hffff, 32'h800);
    rc("clip hi warn", `OFS_STAT, 32'h8, 32'h8);
    check("warn pin", {31'h0, o_warn}, 32'h1);
    wr(`OFS_MDATA, 32'hf800);
    wr(`OFS_CMD, 32'h2);
    wd(1200);
    rc("clip lo", `OFS_MDATA, 32'hffff, 32'hf800);
    rc("clip lo warn", `OFS_STAT, 32'h8, 32'h8);
    wr(`OFS_CFG, 32'h15);
    wr(`OFS_MADDR, 32'h205);
    wr(`OFS_MDATA, 32'h800);
    wr(`OFS_CMD, 32'h1);
    repeat (1200) @(posedge i_core_clk);
    rc("slot1 blocked", `OFS_STAT, 32'h20, 32'h20);
    rc("slot1 kept", `OFS_MDATA, 32'hffff, 32'h800);
    $display("limit test done");
    wr(`OFS_CFG, 32'h34);
    wr(`OFS_CMD, 32'h4);
    rc("three traces", `OFS_STAT, 32'h4, 32'h4);
    wr(`OFS_CFG, 32'h1c);
    wr(`OFS_CMD, 32'h4);
    rc("chop", `OFS_STAT, 32'h4, 32'h4);
    wr(`OFS_CFG, 32'h24);
    wr(`OFS_CMD, 32'h4);
    repeat (5) @(posedge i_core_clk);
    check("live", {31'h0, o_show_live}, 32'h1);
    for (int i = 1; i < 512; i++)
      if (i < 10 || i > 12) pm.sample(i[8:0], 16'(i * 2), 16'(i + 100));
    pm.pulse(0);
    wd(3000);
    wr(`OFS_MADDR, 32'hb);
    rc("interp", `OFS_MDATA, 32'hffff, 32'h16);
    wr(`OFS_MADDR, 32'h0);
    rc("end fill", `OFS_MDATA, 32'hffff, 32'h2);
    wr(`OFS_MADDR, 32'h20b);
    rc("slot1", `OFS_MDATA, 32'hffff, 32'h6f);
    rc("stack", `OFS_STACK, 32'h303, 32'h100);
    rc("scales", `OFS_SCALE, 32'hffff, 32'h4523);
    rc("no warn", `OFS_STAT, 32'h10, 32'h0);
    $display("repetitive test done");
    wr(`OFS_ZREF, 32'h7);
    wr(`OFS_CFG, 32'h20);
    wr(`OFS_CMD, 32'h4);
    repeat (5) @(posedge i_core_clk);
    check("stored", {31'h0, o_show_stored}, 32'h1);
    pm.press(2, 5);
    wd(2000);
    rc("halt warn", `OFS_STAT, 32'h50, 32'h50);
    rc("zref zero", `OFS_ZREF, 32'hffff, 32'h0);
    rc("default scales", `OFS_SCALE, 32'hffff, 32'h0101);
    wr(`OFS_MADDR, 32'h3);
    rc("zeroed", `OFS_MDATA, 32'hffff, 32'h0);
    $display("halt test done");
    wr(`OFS_ZREF, 32'h3);
    wr(`OFS_CFG, 32'h10);
    wr(`OFS_CMD, 32'h8);
    repeat (5) @(posedge i_core_clk);
    check("blocked", {31'h0, o_input_blocked}, 32'h1);
    check("busy", {31'h0, o_busy}, 32'h1);
    check("sgl live", {31'h0, o_show_live}, 32'h1);
    check("sgl stored", {31'h0, o_show_stored}, 32'h0);
    pm.press(0, 5);
    wr(`OFS_CMD, 32'h2);
    for (int i = 0; i < 5; i++) pm.sample(9'h0, 16'(100 + i), 16'h0);
    pm.pulse(1);
    wd(1000);
    rc("ignored", `OFS_ZREF, 32'hffff, 32'h3);
    rc("silent", `OFS_STAT, 32'h18, 32'h0);
    wr(`OFS_MADDR, 32'h1ff);
    rc("newest", `OFS_MDATA, 32'hffff, 32'h68);
    wr(`OFS_MADDR, 32'h1fb);
    rc("oldest", `OFS_MDATA, 32'hffff, 32'h64);
    wr(`OFS_MADDR, 32'h0);
    rc("lead fill", `OFS_MDATA, 32'hffff, 32'h64);
    rc("stack x", `OFS_STACK, 32'h3, 32'h0);
    wr(`OFS_CMD, 32'h8);
    repeat (5) @(posedge i_core_clk);
    pm.pulse(0);
    wd(1000);
    $display("single sweep test done");
    wrap_up;
  end
endmodule // waveform_acquire_and_vposition_tb
